// file: pmm_divide.sv
// Shared constants and the serial divider used by the scaling path
package pmm_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PROTECT_TIME = 8'h04;
	localparam logic [7:0] REG_RESPONSE_DELAY = 8'h08;
	localparam logic [7:0] REG_SETTLE_TIME = 8'h0C;
	localparam logic [7:0] REG_AUTOZERO_TIME = 8'h10;
	localparam logic [7:0] REG_FIRST_INPUT = 8'h14;
	localparam logic [7:0] REG_FIRST_VALUE = 8'h18;
	localparam logic [7:0] REG_SECOND_INPUT = 8'h1C;
	localparam logic [7:0] REG_SECOND_VALUE = 8'h20;
	localparam logic [7:0] REG_PULSE_REF_VALUE = 8'h24;
	localparam logic [7:0] REG_PULSE_REF_FREQ = 8'h28;
	localparam logic [7:0] REG_COMPARE_SET = 8'h2C;
	localparam logic [7:0] REG_STATUS = 8'h30;
	localparam logic [7:0] REG_PROCESS_VALUE = 8'h34;
	// Status bit positions
	localparam int STAT_PROTECT = 0;
	localparam int STAT_MEASURING = 1;
	localparam int STAT_ZERO_FORCED = 2;
	localparam int STAT_PULSE_FAST = 3;
	localparam int STAT_RESP_WAIT = 4;
	// Reset values
	localparam logic [4:0] PROTECT_TIME_RST = 5'h05;
	localparam logic [6:0] RESPONSE_DELAY_RST = 7'h00;
	localparam logic [9:0] SETTLE_TIME_RST = 10'h000;
	localparam logic [15:0] AUTOZERO_TIME_RST = 16'h0032;
	localparam logic [15:0] PULSE_REF_RST = 16'h0001;
	// Programmable limits
	localparam logic [4:0] PROTECT_TIME_MAX = 5'h13;
	localparam logic [6:0] RESPONSE_DELAY_MAX = 7'h63;
	localparam logic [9:0] SETTLE_TIME_MAX = 10'h3E7;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MS = 250;
	localparam int SEC_MS = 1000;
	localparam int TENTH_MS = 100;
	localparam int MHZ_PER_HZ = 1000;
	localparam int FAST_RATE_MHZ = 4000;
	localparam int FAST_MIN_EDGES = (FAST_RATE_MHZ * TICK_MS) / (SEC_MS * MHZ_PER_HZ);
	localparam int EDGE_TO_MHZ = (SEC_MS * MHZ_PER_HZ) / TICK_MS;
	// Input modes
	typedef enum logic [1:0] {
		PMM_MODE_ANALOG = 2'b00,
		PMM_MODE_PULSE = 2'b01,
		PMM_MODE_REMOTE = 2'b10
	} pmm_mode_type;
	// Response delay sequencer
	typedef enum logic [0:0] {
		PMM_RSP_IDLE = 1'b0,
		PMM_RSP_WAIT = 1'b1
	} pmm_rsp_type;
endpackage : pmm_pkg

`timescale 1ns/10ps
// Restoring unsigned divider, one quotient bit per clock
module pmm_divide import pmm_pkg::*; #(
	parameter int W = 64
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic busy,
	output logic done,
	output logic [W-1:0] quo
);
	logic [W-1:0] rem;
	logic [W-1:0] dvs;
	logic [$clog2(W+1)-1:0] cnt;
	logic [W:0] trial;
	logic fits;

	// Shift in the next dividend bit and test against the divisor
	assign trial = {rem, quo[W-1]};
	assign fits = (trial >= {1'b0, dvs});

	// Iterate W times after a start; done pulses once at the end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rem <= '0;
			dvs <= '0;
			quo <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem <= '0;
				dvs <= den;
				quo <= num;
				cnt <= ($clog2(W+1))'(W);
				busy <= 1'b1;
			end else if (busy) begin
				rem <= fits ? W'(trial - {1'b0, dvs}) : trial[W-1:0];
				quo <= {quo[W-2:0], fits};
				cnt <= cnt - 1'b1;
				if (cnt == 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : pmm_divide

// file: pmm_core.sv
// Panel meter measurement core with AHB-Lite register slave
//
// How it works
// RL1: Protect level entered after both keys held for 0 to 19 s, default 5.
// RL2: Response starts 0 to 99 ms after a complete host command frame.
// RL3: Host should pick a delay longer than its own turnaround time.
// RL4: Analog input is sampled on every 250 ms tick.
// RL5: Each analog sample is scaled; value and comparison refresh per sample.
// RL6: Pulses at 4 Hz or more are counted per 250 ms tick.
// RL7: Below 4 Hz frequency is measured from the pulse period itself.
// RL8: Newest host value overwrites the latched one on arrival.
// RL9: Latched host value is taken and scaled on every 250 ms tick.
// RL10: Analog and remote inputs use two-point linear scaling, slope signed.
// RL11: Pulse value is frequency times reference value over reference rate.
// RL12: Pulse timing covers both ranges, intervals up to 20 s.
// RL13: No pulse for the auto-zero time forces frequency to zero.
// RL14: User should set auto-zero longer than the longest pulse gap.
// RL15: Measurement is held off until the settle time after reset.
// RL16: Comparison output depends only on the scaled process value.
// RL17: Settle time applies in pulse mode only, 0.0 to 99.9 s.
// RL18: The 250 ms tick comes from a free counter started at reset release.
// RL19: Auto-zero timer restarts per edge; zero clears on next valid reading.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module pmm_core import pmm_pkg::*; #(
	parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [15:0] ANALOG_DATA,
	input wire logic PULSE_IN,
	input wire logic [15:0] HOST_VALUE,
	input wire logic HOST_VALUE_VALID,
	input wire logic FRAME_DONE,
	input wire logic KEY_LEVEL,
	input wire logic KEY_SHIFT,
	output logic PROTECT_LEVEL,
	output logic RESP_START,
	output logic COMPARE_OUT,
	output logic PV_UPDATE,
	output logic [31:0] PV_VALUE
);
	// Software registers
	pmm_mode_type mode;
	logic [4:0] protect_time;
	logic [6:0] response_delay_code;
	logic [9:0] power_on_settle_time;
	logic [15:0] autozero_time;
	logic signed [15:0] first_input_point;
	logic signed [15:0] first_value_point;
	logic signed [15:0] second_input_point;
	logic signed [15:0] second_value_point;
	logic [15:0] pulse_ref_value;
	logic [15:0] pulse_ref_freq;
	logic signed [31:0] compare_set;
	// Bus state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic ahb_take;
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	// Time base
	logic [31:0] ms_div;
	logic [7:0] tick_ms;
	logic ms_wrap;
	logic ms_tick;
	logic tick;
	// Measurement state
	logic [16:0] settle_ms;
	logic measure_en;
	logic [14:0] hold_ms;
	logic protect_hit;
	logic [15:0] host_latch;
	logic pulse_q;
	logic pulse_rise;
	logic [15:0] edge_cnt;
	logic [15:0] edges_now;
	logic fast_mode;
	logic [31:0] per_cnt;
	logic have_prev;
	logic [23:0] az_ms;
	logic az_hit;
	logic zero_forced;
	// Response delay
	pmm_rsp_type rsp_state;
	logic [23:0] rsp_cnt;
	// Scaling path
	logic signed [15:0] lin_x;
	logic signed [16:0] lin_diff;
	logic signed [16:0] lin_span;
	logic signed [16:0] lin_den;
	logic signed [33:0] lin_prod;
	logic [63:0] lin_num_mag;
	logic [63:0] lin_den_mag;
	logic [63:0] fast_num;
	logic [63:0] slow_num;
	logic [63:0] pulse_den_fast;
	logic [63:0] slow_den;
	logic go_linear;
	logic go_fast;
	logic go_slow;
	logic div_start;
	logic [63:0] div_num;
	logic [63:0] div_den;
	logic div_busy;
	logic div_done;
	logic [63:0] div_quo;
	logic res_neg;
	logic signed [31:0] res_offset;
	logic [31:0] res_mag;
	logic signed [31:0] next_pv;

	// AHB-Lite address phase accepted on NONSEQ and SEQ transfers
	assign ahb_take = HSEL && HREADY && HTRANS[1];

	// Status view of the block's own state
	assign status_word = {27'h0, (rsp_state == PMM_RSP_WAIT), fast_mode,
		zero_forced, measure_en, PROTECT_LEVEL};

	// Read decode; unmapped offsets read as zero
	assign rd_mux =
		(HADDR[7:0] == REG_CTRL) ? {30'h0, mode} :
		(HADDR[7:0] == REG_PROTECT_TIME) ? {27'h0, protect_time} :
		(HADDR[7:0] == REG_RESPONSE_DELAY) ? {25'h0, response_delay_code} :
		(HADDR[7:0] == REG_SETTLE_TIME) ? {22'h0, power_on_settle_time} :
		(HADDR[7:0] == REG_AUTOZERO_TIME) ? {16'h0, autozero_time} :
		(HADDR[7:0] == REG_FIRST_INPUT) ? 32'(first_input_point) :
		(HADDR[7:0] == REG_FIRST_VALUE) ? 32'(first_value_point) :
		(HADDR[7:0] == REG_SECOND_INPUT) ? 32'(second_input_point) :
		(HADDR[7:0] == REG_SECOND_VALUE) ? 32'(second_value_point) :
		(HADDR[7:0] == REG_PULSE_REF_VALUE) ? {16'h0, pulse_ref_value} :
		(HADDR[7:0] == REG_PULSE_REF_FREQ) ? {16'h0, pulse_ref_freq} :
		(HADDR[7:0] == REG_COMPARE_SET) ? compare_set :
		(HADDR[7:0] == REG_STATUS) ? status_word :
		(HADDR[7:0] == REG_PROCESS_VALUE) ? PV_VALUE : 32'h0;

	// Zero-wait slave: read data captured at the address phase
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			HRDATA <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_pend <= ahb_take && HWRITE;
			wr_addr <= HADDR[7:0];
			if (ahb_take && !HWRITE) begin
				HRDATA <= rd_mux;
			end
		end
	end

	// Register writes in the data phase, limits clamped
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			mode <= PMM_MODE_ANALOG;
			protect_time <= PROTECT_TIME_RST;
			response_delay_code <= RESPONSE_DELAY_RST;
			power_on_settle_time <= SETTLE_TIME_RST;
			autozero_time <= AUTOZERO_TIME_RST;
			first_input_point <= 16'h0000;
			first_value_point <= 16'h0000;
			second_input_point <= 16'h0001;
			second_value_point <= 16'h0001;
			pulse_ref_value <= PULSE_REF_RST;
			pulse_ref_freq <= PULSE_REF_RST;
			compare_set <= 32'h0;
		end else if (wr_pend) begin
			case (wr_addr)
				REG_CTRL: mode <= pmm_mode_type'(HWDATA[1:0]);
				REG_PROTECT_TIME: protect_time <= (HWDATA[4:0] > PROTECT_TIME_MAX) ?
					PROTECT_TIME_MAX : HWDATA[4:0]; // [RL1]
				REG_RESPONSE_DELAY: response_delay_code <=
					(HWDATA[6:0] > RESPONSE_DELAY_MAX) ?
					RESPONSE_DELAY_MAX : HWDATA[6:0]; // [RL2]
				REG_SETTLE_TIME: power_on_settle_time <=
					(HWDATA[9:0] > SETTLE_TIME_MAX) ?
					SETTLE_TIME_MAX : HWDATA[9:0]; // [RL17]
				REG_AUTOZERO_TIME: autozero_time <= HWDATA[15:0];
				REG_FIRST_INPUT: first_input_point <= HWDATA[15:0];
				REG_FIRST_VALUE: first_value_point <= HWDATA[15:0];
				REG_SECOND_INPUT: second_input_point <= HWDATA[15:0];
				REG_SECOND_VALUE: second_value_point <= HWDATA[15:0];
				REG_PULSE_REF_VALUE: pulse_ref_value <= HWDATA[15:0];
				REG_PULSE_REF_FREQ: pulse_ref_freq <= HWDATA[15:0];
				REG_COMPARE_SET: compare_set <= HWDATA;
				default: ;
			endcase
		end
	end

	// Free-running millisecond divider and 250 ms tick from reset release
	assign ms_wrap = (ms_div == 32'(CYCLES_PER_MS - 1));
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ms_div <= 32'h0;
			tick_ms <= 8'h00;
			ms_tick <= 1'b0;
			tick <= 1'b0;
		end else begin
			ms_div <= ms_wrap ? 32'h0 : ms_div + 32'h1; // [RL18]
			ms_tick <= ms_wrap;
			tick <= ms_wrap && (tick_ms == 8'(TICK_MS - 1)); // [RL18]
			if (ms_wrap) begin
				tick_ms <= (tick_ms == 8'(TICK_MS - 1)) ? 8'h00 : tick_ms + 8'h01;
			end
		end
	end

	// Settle timer counts from reset; gates measurement in pulse mode
	assign measure_en = (mode != PMM_MODE_PULSE) ||
		(settle_ms >= 17'(power_on_settle_time * TENTH_MS)); // [RL15] [RL17]
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			settle_ms <= 17'h0;
		end else if (ms_tick && settle_ms != 17'h1FFFF) begin
			settle_ms <= settle_ms + 17'h1;
		end
	end

	// Key hold timer; protect level is sticky, set wins over clear
	assign protect_hit = KEY_LEVEL && KEY_SHIFT &&
		(hold_ms >= 15'(protect_time * SEC_MS)); // [RL1]
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			hold_ms <= 15'h0;
			PROTECT_LEVEL <= 1'b0;
		end else begin
			if (!(KEY_LEVEL && KEY_SHIFT)) begin
				hold_ms <= 15'h0; // [RL1]
			end else if (ms_tick && hold_ms != 15'h7FFF) begin
				hold_ms <= hold_ms + 15'h1;
			end
			if (protect_hit) begin
				PROTECT_LEVEL <= 1'b1;
			end else if (wr_pend && wr_addr == REG_STATUS && HWDATA[STAT_PROTECT]) begin
				PROTECT_LEVEL <= 1'b0;
			end
		end
	end

	// Response delay after a complete command frame
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rsp_state <= PMM_RSP_IDLE;
			rsp_cnt <= 24'h0;
			RESP_START <= 1'b0;
		end else begin
			RESP_START <= 1'b0;
			if (FRAME_DONE) begin
				rsp_state <= PMM_RSP_WAIT;
				rsp_cnt <= 24'h0;
			end else begin
				case (rsp_state)
					PMM_RSP_IDLE: ;
					PMM_RSP_WAIT: begin
						if (rsp_cnt >= 24'(response_delay_code * CYCLES_PER_MS)) begin
							RESP_START <= 1'b1; // [RL2]
							rsp_state <= PMM_RSP_IDLE;
						end else begin
							rsp_cnt <= rsp_cnt + 24'h1;
						end
					end
					default: rsp_state <= PMM_RSP_IDLE;
				endcase
			end
		end
	end

	// Host value latch, newest wins
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			host_latch <= 16'h0;
		end else if (HOST_VALUE_VALID) begin
			host_latch <= HOST_VALUE; // [RL8]
		end
	end

	// Pulse edge, per-tick count, period and auto-zero timers
	assign pulse_rise = PULSE_IN && !pulse_q;
	assign edges_now = edge_cnt + 16'(pulse_rise);
	assign az_hit = (az_ms >= 24'(autozero_time * TENTH_MS)) && !zero_forced;
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			pulse_q <= 1'b0;
			edge_cnt <= 16'h0;
			fast_mode <= 1'b0;
			per_cnt <= 32'h0;
			have_prev <= 1'b0;
			az_ms <= 24'h0;
			zero_forced <= 1'b0;
		end else begin
			pulse_q <= PULSE_IN;
			if (tick) begin
				edge_cnt <= 16'h0;
				fast_mode <= (edges_now >= 16'(FAST_MIN_EDGES)); // [RL6] [RL7]
			end else if (pulse_rise && edge_cnt != 16'hFFFF) begin
				edge_cnt <= edge_cnt + 16'h1;
			end else if (az_hit && mode == PMM_MODE_PULSE) begin
				edge_cnt <= 16'h0; // Stale edges must not undo the zero [RL13]
			end
			// Period counter saturates, spans gaps beyond 20 s
			if (pulse_rise) begin
				per_cnt <= 32'h0; // [RL12]
				have_prev <= 1'b1;
			end else if (per_cnt != 32'hFFFFFFFF) begin
				per_cnt <= per_cnt + 32'h1;
			end
			if (pulse_rise) begin
				az_ms <= 24'h0; // [RL19]
			end else if (ms_tick && az_ms != 24'hFFFFFF) begin
				az_ms <= az_ms + 24'h1;
			end
			if (go_fast || go_slow) begin
				zero_forced <= 1'b0; // [RL19]
			end else if (az_hit && mode == PMM_MODE_PULSE) begin
				zero_forced <= 1'b1; // [RL13]
				have_prev <= 1'b0;
			end
		end
	end

	// Two-point linear scaling terms, signed slope allowed
	assign lin_x = (mode == PMM_MODE_REMOTE) ? host_latch : ANALOG_DATA; // [RL9]
	assign lin_diff = 17'(lin_x) - 17'(first_input_point); // [RL10]
	assign lin_span = 17'(second_value_point) - 17'(first_value_point);
	assign lin_den = 17'(second_input_point) - 17'(first_input_point);
	assign lin_prod = 34'(lin_diff) * 34'(lin_span);
	assign lin_num_mag = {30'h0, lin_prod[33] ? 34'(-lin_prod) : lin_prod};
	assign lin_den_mag = {47'h0, lin_den[16] ? 17'(-lin_den) : lin_den};

	// Pulse scaling: value = f * reference value / reference rate
	assign fast_num = 64'(edges_now) * 64'(EDGE_TO_MHZ) * 64'(pulse_ref_value);
	assign pulse_den_fast = 64'(pulse_ref_freq) * 64'(MHZ_PER_HZ); // [RL11]
	assign slow_num = 64'(CYCLES_PER_MS) * 64'(SEC_MS * MHZ_PER_HZ) *
		64'(pulse_ref_value);
	assign slow_den = (64'(per_cnt) + 64'h1) * pulse_den_fast; // [RL7] [RL11]

	// Measurement triggers per input mode
	assign go_linear = tick && measure_en && !div_busy &&
		(mode == PMM_MODE_ANALOG || mode == PMM_MODE_REMOTE); // [RL4] [RL9]
	assign go_fast = tick && measure_en && !div_busy && !az_hit &&
		mode == PMM_MODE_PULSE && edges_now >= 16'(FAST_MIN_EDGES); // [RL6]
	assign go_slow = pulse_rise && !tick && measure_en && !div_busy &&
		mode == PMM_MODE_PULSE && !fast_mode && have_prev; // [RL7]
	assign div_num = go_linear ? lin_num_mag : (go_fast ? fast_num : slow_num);
	assign div_den = go_linear ? lin_den_mag :
		(go_fast ? pulse_den_fast : slow_den);
	assign div_start = (go_linear || go_fast || go_slow) && (div_den != 64'h0);

	pmm_divide #(
		.W(64)
	) u_divide (
		.clk(MCLK),
		.rst_b(RST_B),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.busy(div_busy),
		.done(div_done),
		.quo(div_quo)
	);

	// Sign and offset held for the running division
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			res_neg <= 1'b0;
			res_offset <= 32'h0;
		end else if (div_start) begin
			res_neg <= go_linear && (lin_prod[33] ^ lin_den[16]); // [RL10]
			res_offset <= go_linear ? 32'(first_value_point) : 32'h0;
		end
	end

	// Process value and comparison refresh together
	assign res_mag = div_quo[31:0];
	assign next_pv = res_offset + (res_neg ? 32'(-res_mag) : res_mag);
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			PV_VALUE <= 32'h0;
			COMPARE_OUT <= 1'b0;
			PV_UPDATE <= 1'b0;
		end else begin
			PV_UPDATE <= div_done || (az_hit && mode == PMM_MODE_PULSE);
			if (div_done) begin
				PV_VALUE <= next_pv; // [RL5]
				COMPARE_OUT <= (next_pv >= compare_set); // [RL16]
			end else if (az_hit && mode == PMM_MODE_PULSE) begin
				PV_VALUE <= 32'h0; // [RL13]
				COMPARE_OUT <= (compare_set <= 32'sh0); // [RL16]
			end
		end
	end
endmodule : pmm_core

// file: pmm_core_sva.sv
// Concurrent checks on the measurement core ports
`timescale 1ns/10ps
module pmm_core_sva #(
	parameter int unsigned CYCLES_PER_MS = 100000
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic FRAME_DONE,
	input wire logic KEY_LEVEL,
	input wire logic KEY_SHIFT,
	input wire logic PROTECT_LEVEL,
	input wire logic RESP_START,
	input wire logic COMPARE_OUT,
	input wire logic PV_UPDATE,
	input wire logic [31:0] PV_VALUE
);
	logic [31:0] since_frame;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	// Edges since the last frame end, saturating
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			since_frame <= 32'h0;
		else if (FRAME_DONE)
			since_frame <= 32'h1;
		else if (since_frame != 32'h0 && since_frame != 32'hFFFFFFFF)
			since_frame <= since_frame + 32'h1;
	end
	ready_okay_a: assert property (HREADYOUT && !HRESP)
		else $error("bus stalled or error response");
	rdata_hold_a: assert property ($changed(HRDATA) |->
		$past(HSEL && HREADY && HTRANS[1] && !HWRITE))
		else $error("read data moved without a read");
	// Reply strobe is seen whole milliseconds plus two edges after the frame
	resp_delay_a: assert property (RESP_START |->
		since_frame % CYCLES_PER_MS == 2 &&
		since_frame <= 99 * CYCLES_PER_MS + 2)
		else $error("reply start off the delay grid");
	resp_pulse_a: assert property (RESP_START |=> !RESP_START)
		else $error("reply start wider than a cycle");
	protect_keys_a: assert property ($rose(PROTECT_LEVEL) |->
		$past(KEY_LEVEL && KEY_SHIFT) && $past(KEY_LEVEL && KEY_SHIFT, 2))
		else $error("protect entered without both keys");
	pv_pulse_a: assert property (PV_UPDATE |=> !PV_UPDATE [*4])
		else $error("update strobe too wide");
	pv_hold_a: assert property ($changed(PV_VALUE) |-> PV_UPDATE)
		else $error("value moved without update");
	cmp_hold_a: assert property ($changed(COMPARE_OUT) |-> PV_UPDATE)
		else $error("compare moved without update");
endmodule : pmm_core_sva

bind pmm_core pmm_core_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_sva (
	.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .FRAME_DONE(FRAME_DONE),
	.KEY_LEVEL(KEY_LEVEL), .KEY_SHIFT(KEY_SHIFT),
	.PROTECT_LEVEL(PROTECT_LEVEL), .RESP_START(RESP_START),
	.COMPARE_OUT(COMPARE_OUT), .PV_UPDATE(PV_UPDATE),
	.PV_VALUE(PV_VALUE));

// file: pmm_host.sv
// Host model: sends values and command frames, times the reply
`timescale 1ns/10ps
module pmm_host (
	input wire logic mclk,
	input wire logic resp_start,
	output logic frame_done,
	output logic [15:0] host_value,
	output logic host_value_valid
);
	initial begin
		frame_done = 1'b0;
		host_value = 16'h0000;
		host_value_valid = 1'b0;
	end
	// One-cycle strobe; released data shows the inverse afterwards
	task send(input logic [15:0] v);
		@(posedge mclk);
		host_value <= v;
		host_value_valid <= 1'b1;
		@(posedge mclk);
		host_value <= ~v;
		host_value_valid <= 1'b0;
	endtask : send
	// Frame end, then stay ready until the reply starts
	task frame(output int n);
		@(posedge mclk);
		frame_done <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			frame_done <= 1'b0;
			n++;
		end while (resp_start !== 1'b1);
	endtask : frame
endmodule : pmm_host

// file: tb_top.sv
// Self-checking testbench for the panel meter measurement core
`timescale 1ns/10ps
module tb_top;
	import pmm_pkg::*;
	localparam int CPM = 10;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] hwdata = '0;
	logic [15:0] adc = '0;
	logic pulse_in = 1'b0;
	logic key_a = 1'b0;
	logic key_b = 1'b0;
	logic hready, prot, rsp, cmp, pvu, fdone, hval;
	logic [31:0] hrdata, pv, rd;
	logic [15:0] hv;
	logic [7:0] ra[4] = '{8'h04, 8'h10, 8'h1C, 8'h3C};
	logic [31:0] rv[4] = '{32'h5, 32'h32, 32'h1, 32'h0};
	logic [7:0] wa[3] = '{8'h04, 8'h08, 8'h3C};
	logic [31:0] wd[3] = '{32'h1F, 32'h7F, 32'hFFFF};
	logic [31:0] we[3] = '{32'h13, 32'h63, 32'h0};
	int dl[3] = '{0, 3, 99};
	int n_mismatch = 0;
	int num_checks = 0;
	int seed = 32'ha7d0;
	int per = 0;
	int pcnt = 0;
	int cyc = 0;
	int k;
	longint x;

	always #5 mclk = ~mclk;

	pmm_core #(.CYCLES_PER_MS(CPM)) u_dut (.MCLK(mclk), .RST_B(rst_b),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
		.ANALOG_DATA(adc), .PULSE_IN(pulse_in), .HOST_VALUE(hv),
		.HOST_VALUE_VALID(hval), .FRAME_DONE(fdone), .KEY_LEVEL(key_a),
		.KEY_SHIFT(key_b), .PROTECT_LEVEL(prot), .RESP_START(rsp),
		.COMPARE_OUT(cmp), .PV_UPDATE(pvu), .PV_VALUE(pv));
	pmm_host u_host (.mclk(mclk), .resp_start(rsp), .frame_done(fdone),
		.host_value(hv), .host_value_valid(hval));

	// Pulse source and edge count since reset release
	always @(posedge mclk) begin
		pcnt <= (per == 0 || pcnt >= per - 1) ? 0 : pcnt + 1;
		pulse_in <= (per != 0 && pcnt == 0);
		cyc <= rst_b ? cyc + 1 : 0;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// Single AHB-Lite word transfer; read data lands in rd
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task wait_pv(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pvu !== 1'b1);
	endtask : wait_pv

	// Points (-100, 500) and (900, -1300)
	function automatic longint scale(longint v);
		return 500 + (v + 100) * (-1800) / 1000;
	endfunction : scale

	task do_reset;
		rst_b <= 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
	endtask : do_reset

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		end_of_test;
	end

	initial begin
		adc <= $random(seed);
		do_reset;
		wait_pv(k);
		check(k >= 250 * CPM + 64 && k <= 250 * CPM + 69, 1);
		check(pv, {{16{adc[15]}}, adc});
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 0);
			check(rd, rv[i]);
		end
		foreach (wa[i]) begin
			bus(1'b1, wa[i], wd[i]);
			bus(1'b0, wa[i], 0);
			check(rd, we[i]);
		end
		foreach (dl[i]) begin
			bus(1'b1, REG_RESPONSE_DELAY, dl[i]);
			u_host.frame(k);
			check(k, dl[i] * CPM + 3);
		end
		// A key slip restarts the protect hold
		bus(1'b1, REG_PROTECT_TIME, 1);
		key_a <= 1'b1;
		key_b <= 1'b1;
		repeat (300 * CPM) @(posedge mclk);
		key_b <= 1'b0;
		@(posedge mclk);
		key_b <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (prot !== 1'b1);
		check(k >= 999 * CPM && k <= 1000 * CPM + 3, 1);
		key_a <= 1'b0;
		key_b <= 1'b0;
		bus(1'b1, REG_STATUS, 1);
		bus(1'b0, REG_STATUS, 0);
		check({rd[0], prot}, 0);
		// Analog mode, inverse scale
		bus(1'b1, REG_FIRST_INPUT, 32'hFF9C);
		bus(1'b1, REG_FIRST_VALUE, 32'h1F4);
		bus(1'b1, REG_SECOND_INPUT, 32'h384);
		bus(1'b1, REG_SECOND_VALUE, 32'hFAEC);
		bus(1'b1, REG_COMPARE_SET, 0);
		wait_pv(k);
		repeat (3) begin
			x = $random(seed) % 1000;
			adc <= x[15:0];
			wait_pv(k);
			check(k, 250 * CPM);
			check(pv, scale(x));
			check(cmp, scale(x) >= 0);
		end
		// Remote mode keeps the newest host value
		bus(1'b1, REG_CTRL, 2);
		wait_pv(k);
		repeat (2) begin
			x = $random(seed) % 1000;
			u_host.send(x[15:0]);
		end
		wait_pv(k);
		// The two sends used four of the interval's edges
		check(k, 250 * CPM - 4);
		check(pv, scale(x));
		// Pulse mode: settle, fast rate, auto-zero, recovery
		do_reset;
		bus(1'b1, REG_SETTLE_TIME, 3);
		bus(1'b1, REG_AUTOZERO_TIME, 2);
		bus(1'b1, REG_PULSE_REF_VALUE, 60);
		bus(1'b1, REG_CTRL, 1);
		per <= 50;
		wait_pv(k);
		check(cyc >= 300 * CPM, 1);
		check(pv, 12000);
		wait_pv(k);
		check(k, 250 * CPM);
		per <= 0;
		repeat (500 * CPM) @(posedge mclk);
		check(pv, 0);
		bus(1'b0, REG_STATUS, 0);
		check(rd[2], 1);
		per <= 50;
		repeat (600 * CPM) @(posedge mclk);
		bus(1'b0, REG_STATUS, 0);
		check(rd[2], 0);
		check(pv, 12000);
		end_of_test;
	end
endmodule : tb_top
